//--- pin_sync.sv
/*
  Two-flop synchroniser for a bundle of pins.
  Assumes the pins change slowly relative to the clock, so bundle skew of one
  cycle between bits is harmless.
*/
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(parameter int W = 21) (
  // Clock and reset.
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Pins in, synchronised copy out.
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule : pin_sync
`default_nettype wire

//--- pixel_fifo.sv
/*
  Small shift-register FIFO; the head entry and its valid bit are flops, so
  the drain side sees registered outputs.
  Assumes one clock for both sides. A push is refused while the last slot is
  occupied, even if a pop happens in the same cycle.
*/
`timescale 1ns/10ps
`default_nettype none
module pixel_fifo #(
  parameter int W     = 17,
  parameter int DEPTH = 4
) (
  // Clock and reset.
  input  wire logic    clk_sys,
  input  wire logic    rst,
  // Fill and drain sides.
  pixel_stream_if.sink   fill,
  pixel_stream_if.source drain
);
  logic [W-1:0] mem      [DEPTH];
  logic [W-1:0] next_mem [DEPTH];
  logic [DEPTH-1:0] vld;
  logic [DEPTH-1:0] next_vld;
  logic pop;
  logic push;
  logic placed;

  assign fill.ready  = !vld[DEPTH-1];
  assign drain.valid = vld[0];
  assign drain.data  = mem[0];
  assign pop  = vld[0] && drain.ready;
  assign push = fill.valid && !vld[DEPTH-1];

  always_comb begin
    placed = 1'b0;
    for (int i = 0; i < DEPTH; i++) begin
      next_mem[i] = mem[i];
      next_vld[i] = vld[i];
    end
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_mem[i] = mem[i+1];
        next_vld[i] = vld[i+1];
      end
      next_vld[DEPTH-1] = 1'b0;
    end
    for (int i = 0; i < DEPTH; i++) begin
      if (push && !placed && !next_vld[i]) begin
        next_vld[i] = 1'b1;
        next_mem[i] = fill.data;
        placed      = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      vld <= '0;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      vld <= next_vld;
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= next_mem[i];
      end
    end
  end
endmodule : pixel_fifo
`default_nettype wire

//--- pixel_stream_if.sv
/*
  Valid/ready stream carrier between the sampler and its output buffer.
  Assumes both ends sit on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface pixel_stream_if #(parameter int W = 17);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : pixel_stream_if
`default_nettype wire

//--- tb.sv
/*
  Self-checking bench for the video input sampler: plays frames from the
  source model and compares the drained pixel stream with the window.
  Assumes the design files and the source model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
module tb
  import video_input_pkg::*;
;
  localparam int PIX   = 12;
  localparam int LINES = 6;

  logic               clk_sys = 1'b0;
  logic               rst = 1'b1;
  logic               video_clk, qual, hs, vs, par_pin;
  logic [LANE_W-1:0]  luma, chroma, pixel_luma, pixel_chroma;
  logic               qpol = 1'b1;
  logic               hs_inv = 1'b0;
  logic               vs_inv = 1'b0;
  logic               vs_late = 1'b0;
  logic               par_level = 1'b0;
  logic               ext_en = 1'b0;
  logic               upper = 1'b1;
  logic               hs_sel = 1'b0;
  logic               vs_sel = 1'b0;
  logic [COUNT_W-1:0] fl = 10'h001;
  logic [COUNT_W-1:0] ll = 10'h003;
  logic [COUNT_W-1:0] fp = 10'h003;
  logic [COUNT_W-1:0] lp = 10'h006;
  logic               capture_active, field_top, overflow, pixel_valid, pixel_top;
  logic               pixel_ready = 1'b1;
  logic [WORD_W-1:0]  rx[$];
  logic [WORD_W-1:0]  want[$];
  int                 err_count = 0;
  int                 samples_checked = 0;
  int                 ovf_seen = 0;

  always #20 clk_sys = ~clk_sys;

  video_source_model #(.PIX(PIX), .LINES(LINES)) video_source_model_i (
    .video_clk(video_clk), .qual(qual), .luma(luma), .chroma(chroma), .hs(hs), .vs(vs),
    .par_pin(par_pin), .qpol(qpol), .hs_inv(hs_inv), .vs_inv(vs_inv), .vs_late(vs_late),
    .par_level(par_level)
  );

  video_input_sampler video_input_sampler_i (
    .clk_sys(clk_sys), .rst(rst),
    .double_rate_video_clock(video_clk), .sample_qualifier(qual),
    .luma_lanes(luma), .chroma_lanes(chroma), .line_sync(hs), .frame_sync(vs),
    .parity_indicator_pin(par_pin), .qualifier_polarity(qpol),
    .external_parity_enable(ext_en), .upper_parity_level(upper),
    .line_sync_edge_select(hs_sel), .frame_sync_edge_select(vs_sel),
    .first_line_count(fl), .last_line_count(ll),
    .first_pixel_count(fp), .last_pixel_count(lp),
    .capture_active(capture_active), .field_top(field_top), .overflow(overflow),
    .pixel_ready(pixel_ready), .pixel_valid(pixel_valid),
    .pixel_luma(pixel_luma), .pixel_chroma(pixel_chroma), .pixel_top(pixel_top)
  );

  always @(posedge clk_sys) begin
    if (pixel_valid === 1'b1 && pixel_ready === 1'b1)
      rx.push_back({pixel_top, pixel_luma, pixel_chroma});
    if (overflow === 1'b1)
      ovf_seen++;
  end

  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask : step

  task automatic check(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp,
                       input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // Plays one frame; ds and dl map a counted position to the source sample
  // and line that should land there, which the lanes carry as luma and chroma.
  task automatic run(input int ds, input int dl, input logic top, input logic stall);
    int s;
    int l;
    rx = {};
    want = {};
    ovf_seen = 0;
    for (int y = int'(fl); y <= int'(ll); y++) begin
      for (int x = int'(fp); x <= int'(lp); x++) begin
        s = x + ds;
        l = y + dl;
        if (s < PIX && l >= 0 && l < LINES)
          want.push_back({top, 8'(s), 8'(l)});
      end
    end
    pixel_ready = ~stall;
    video_source_model_i.play();
    step();
    pixel_ready = 1'b1;
    if (stall) begin
      check(WORD_W'(ovf_seen), WORD_W'(want.size() - FIFO_DEPTH), "drops");
      want = want[0:FIFO_DEPTH-1];
    end
    for (int n = 0; n < 40 && rx.size() < want.size(); n++) begin
      @(posedge clk_sys);
    end
    if (rx.size() < want.size()) begin
      err_count++;
      $display("mismatch at %0t: stream stalled", $time);
      print_verdict();
    end else begin
      repeat (8) step();
      check(WORD_W'(rx.size()), WORD_W'(want.size()), "count");
      for (int i = 0; i < want.size() && i < rx.size(); i++) begin
        check(rx[i], want[i], "word");
      end
    end
  endtask : run

  task automatic t_window();
    step();
    run(0, 0, 1'b1, 1'b0);
    $display("window test done");
  endtask : t_window

  task automatic t_qual_low();
    step();
    qpol = 1'b0;
    run(0, 0, 1'b1, 1'b0);
    qpol = 1'b1;
    $display("qualifier test done");
  endtask : t_qual_low

  // A pulse whose active edge is the other one shifts the counts.
  task automatic t_sync_edges();
    step();
    vs_sel = 1'b1;
    run(0, 1, 1'b1, 1'b0);
    vs_sel = 1'b0;
    hs_sel = 1'b1;
    run(2, -1, 1'b1, 1'b0);
    {hs_inv, vs_inv, vs_sel, upper} = 4'b1110;
    run(0, 0, 1'b1, 1'b0);
    {hs_inv, vs_inv, hs_sel, vs_sel, upper} = 5'b00001;
    $display("sync edge test done");
  endtask : t_sync_edges

  task automatic t_field();
    logic [4:0] tbl [6];
    logic       top;
    tbl = '{5'b00101, 5'b00110, 5'b00011, 5'b11101, 5'b10100, 5'b10001};
    step();
    {fl, ll, fp, lp} = {10'h001, 10'h001, 10'h003, 10'h003};
    foreach (tbl[i]) begin
      {ext_en, par_level, upper, vs_late, top} = tbl[i];
      run(0, 0, top, 1'b0);
      check(WORD_W'(field_top), WORD_W'(top), "field");
    end
    {ext_en, par_level, upper, vs_late} = 4'b0010;
    $display("field test done");
  endtask : t_field

  task automatic t_full_frame();
    step();
    // The last line stays outside, so the capture flag is low before the
    // next scenario moves the window.
    {fl, ll, fp, lp} = {10'h000, 10'h004, 10'h000, COUNT_MAX};
    run(0, 0, 1'b1, 1'b0);
    $display("full frame test done");
  endtask : t_full_frame

  // A line without line sync runs the pixel count into its ceiling, where it
  // must stay; a wrapping count would hit the last pixel only once.
  task automatic t_saturate();
    step();
    {fl, ll, fp, lp} = {COUNT_RESET, COUNT_MAX, COUNT_MAX, COUNT_MAX};
    video_source_model_i.emit(9, 0, 1'b0);
    rx = {};
    for (int n = 0; n < 1030; n++) begin
      video_source_model_i.emit(9, 5, 1'b0);
    end
    check(WORD_W'(capture_active), WORD_W'(1'b1), "window flag");
    video_source_model_i.emit(9, 0, 1'b0);
    check(WORD_W'(capture_active), WORD_W'(1'b0), "window flag");
    repeat (8) step();
    check(WORD_W'(rx.size()), WORD_W'(8), "ceiling count");
    if (rx.size() > 0)
      check(rx[0], {1'b1, 8'h05, 8'h09}, "ceiling word");
    $display("saturation test done");
  endtask : t_saturate

  task automatic t_overflow();
    step();
    {fl, ll, fp, lp} = {10'h001, 10'h003, 10'h003, 10'h006};
    run(0, 0, 1'b1, 1'b1);
    $display("overflow test done");
  endtask : t_overflow

  task automatic print_verdict();
    $display("checked %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (12) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (2) step();
    t_window();
    t_qual_low();
    t_sync_edges();
    t_field();
    t_full_frame();
    t_saturate();
    t_overflow();
    print_verdict();
  end
endmodule : tb
`default_nettype wire

//--- video_input_pkg.sv
/*
  Shared constants and types for the video input sampler: counter widths,
  reset values, stream word layout, buffer depth and the capture state type.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package video_input_pkg;

  // Position counters cover a total frame of up to 1023 by 1023.
  localparam int          COUNT_W     = 10;
  localparam logic [9:0]  COUNT_MAX   = 10'h3ff;
  localparam logic [9:0]  COUNT_RESET = 10'h000;

  // Lanes and stream word layout: {top field, luma, chroma}.
  localparam int          LANE_W      = 8;
  localparam int          WORD_W      = 17;
  localparam int          TOP_BIT     = 16;
  localparam int          LUMA_LSB    = 8;
  localparam int          CHROMA_LSB  = 0;
  localparam logic [16:0] WORD_RESET  = 17'h00000;

  // Synchronised pin bundle layout.
  localparam int          PIN_W       = 21;
  localparam int          PIN_VID_CLK = 20;
  localparam int          PIN_QUAL    = 19;
  localparam int          PIN_HS      = 18;
  localparam int          PIN_VS      = 17;
  localparam int          PIN_PARITY  = 16;
  localparam int          PIN_LUMA    = 8;
  localparam int          PIN_CHROMA  = 0;

  localparam int          FIFO_DEPTH  = 4;

  // Source clock limits, kept for reference; neither the bench nor the source model uses them.
  localparam real         VIDEO_CLK_MIN_MHZ = 24.0;
  localparam real         VIDEO_CLK_MAX_MHZ = 30.0;

  typedef enum logic [1:0] {
    st_hunt   = 2'b01,
    st_locked = 2'b10
  } frame_state_type;

endpackage : video_input_pkg

//--- video_input_sampler.sv
/*
  Capture front end for a YUV 4:2:2 video input: qualified sampling, line and
  pixel counting from selectable sync edges, window cropping, field identity.
  Assumes the video pins are asynchronous to clk_sys and that clk_sys runs
  well above the double-rate video clock, so every edge is seen; the
  configuration ports come from logic on clk_sys and are held steady.
*/
// Overview of operation
// R1 - Lanes and syncs are taken only on qualified rising edges of the video clock.
// R2 - Qualifier polarity one samples with qualifier high; zero samples with it low.
// R3 - The source keeps the double-rate clock between 24.0 and 30.0 MHz; the bench source model runs it at 3.125 MHz.
// R4 - External parity enable picks the parity pin, else syncs give field identity.
// R5 - From the pin, top field is the pin level equal to the upper parity level.
// R6 - Internally, line sync level at the frame sync edge matching upper level means top.
// R7 - Capture starts at the line whose count from frame sync equals the first line count.
// R8 - Capture stops after the line whose count equals the last line count.
// R9 - First captured pixel is at the first pixel count from the line sync edge.
// R10 - Last captured pixel is at the last pixel count from the line sync edge.
// R11 - Line sync edge select one counts pixels from the falling edge, else rising.
// R12 - Frame sync edge select one counts lines from the falling edge, else rising.
// R13 - Pixel and line counters are ten bits and cover up to 1023.
// R14 - Any window from 32 by 32 to 1023 by 1023 is supported, step one.
// R15 - Counters clear on their sync edges; capture flags only inside both ranges.
`timescale 1ns/10ps
`default_nettype none
module video_input_sampler
  import video_input_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Video source pins.
  input  wire logic              double_rate_video_clock,
  input  wire logic              sample_qualifier,
  input  wire logic [LANE_W-1:0] luma_lanes,
  input  wire logic [LANE_W-1:0] chroma_lanes,
  input  wire logic              line_sync,
  input  wire logic              frame_sync,
  input  wire logic              parity_indicator_pin,
  // Configuration.
  input  wire logic              qualifier_polarity,
  input  wire logic              external_parity_enable,
  input  wire logic              upper_parity_level,
  input  wire logic              line_sync_edge_select,
  input  wire logic              frame_sync_edge_select,
  input  wire logic [COUNT_W-1:0] first_line_count,
  input  wire logic [COUNT_W-1:0] last_line_count,
  input  wire logic [COUNT_W-1:0] first_pixel_count,
  input  wire logic [COUNT_W-1:0] last_pixel_count,
  // Status.
  output var  logic              capture_active,
  output var  logic              field_top,
  output var  logic              overflow,
  // Captured pixel stream.
  input  wire logic              pixel_ready,
  output var  logic              pixel_valid,
  output var  logic [LANE_W-1:0] pixel_luma,
  output var  logic [LANE_W-1:0] pixel_chroma,
  output var  logic              pixel_top
);

  // An edge is active when it goes the way the select bit asks.
  function automatic logic active_edge(input logic falling, input logic last,
                                       input logic now);
    active_edge = falling ? (last && !now) : (!last && now);
  endfunction : active_edge

  // Counters saturate so a missing sync cannot wrap into the window.
  function automatic logic [COUNT_W-1:0] bump(input logic [COUNT_W-1:0] c);
    bump = (c == COUNT_MAX) ? COUNT_MAX : c + 10'h001;
  endfunction : bump

  // Both range ends are inclusive, so a window one pixel wide is legal.
  function automatic logic in_range(input logic [COUNT_W-1:0] c,
                                    input logic [COUNT_W-1:0] lo,
                                    input logic [COUNT_W-1:0] hi);
    in_range = (c >= lo) && (c <= hi);
  endfunction : in_range

  logic [PIN_W-1:0]   pins_s;
  logic               vid_clk_now;
  logic               qual_now;
  logic               hs_now;
  logic               vs_now;
  logic               par_now;
  logic               pix_evt;
  logic               h_edge;
  logic               v_edge;
  logic               win;

  frame_state_type    state;
  frame_state_type    next_state;
  logic               vid_clk_last;
  logic               hs_last;
  logic               next_hs_last;
  logic               vs_last;
  logic               next_vs_last;
  logic [COUNT_W-1:0] line_cnt;
  logic [COUNT_W-1:0] next_line_cnt;
  logic [COUNT_W-1:0] pixel_cnt;
  logic [COUNT_W-1:0] next_pixel_cnt;
  logic               next_field_top;
  logic               next_capture_active;
  logic               push_valid;
  logic               next_push_valid;
  logic [WORD_W-1:0]  push_word;
  logic [WORD_W-1:0]  next_push_word;
  logic               next_overflow;

  pixel_stream_if #(.W(WORD_W)) fill_bus ();
  pixel_stream_if #(.W(WORD_W)) drain_bus ();

  pin_sync #(.W(PIN_W)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({double_rate_video_clock, sample_qualifier, line_sync, frame_sync,
               parity_indicator_pin, luma_lanes, chroma_lanes}),
    .q       (pins_s)
  );

  assign vid_clk_now = pins_s[PIN_VID_CLK];
  assign qual_now    = pins_s[PIN_QUAL];
  assign hs_now      = pins_s[PIN_HS];
  assign vs_now      = pins_s[PIN_VS];
  assign par_now     = pins_s[PIN_PARITY];

  // The qualifier is sampled together with the clock, so board skew between
  // them only matters if it exceeds half a video clock.
  assign pix_evt = vid_clk_now && !vid_clk_last                 // R1
                   && (qual_now == qualifier_polarity);         // R2
  assign h_edge  = active_edge(line_sync_edge_select, hs_last, hs_now);  // R11
  assign v_edge  = active_edge(frame_sync_edge_select, vs_last, vs_now); // R12

  always_comb begin
    next_state          = state;
    next_hs_last        = hs_last;
    next_vs_last        = vs_last;
    next_line_cnt       = line_cnt;
    next_pixel_cnt      = pixel_cnt;
    next_field_top      = field_top;
    next_capture_active = capture_active;
    next_push_valid     = 1'b0;
    next_push_word      = push_word;
    win                 = 1'b0;
    if (pix_evt) begin
      next_hs_last = hs_now;
      next_vs_last = vs_now;
      // A frame edge wins over a line edge in the same sample, so the line
      // that opens with the frame edge is line zero. Sync edges are only seen
      // between two qualified samples, never on the unqualified slot.
      if (v_edge) begin
        next_line_cnt = COUNT_RESET;                            // R15
        next_state    = st_locked;
        if (!external_parity_enable) begin                      // R4
          next_field_top = (hs_now == upper_parity_level);      // R6
        end
      end else if (h_edge) begin
        next_line_cnt = bump(line_cnt);                         // R13
      end
      if (h_edge) begin
        next_pixel_cnt = COUNT_RESET;                           // R15
      end else begin
        next_pixel_cnt = bump(pixel_cnt);                       // R13
      end
      if (external_parity_enable) begin                         // R4
        next_field_top = (par_now == upper_parity_level);       // R5
      end
      case (next_state)
        st_hunt:   win = 1'b0;
        st_locked: win = in_range(next_line_cnt, first_line_count,
                                  last_line_count)              // R7 R8 R14
                         && in_range(next_pixel_cnt, first_pixel_count,
                                     last_pixel_count);         // R9 R10
        default:   win = 1'b0;
      endcase
      next_capture_active = win;                                // R15
      next_push_valid     = win;
      next_push_word      = {next_field_top, pins_s[PIN_LUMA +: LANE_W],
                             pins_s[PIN_CHROMA +: LANE_W]};
    end
    // A pixel the buffer cannot take is dropped and flagged for one cycle.
    // The source cannot be held off, so dropping is the only way out.
    next_overflow = push_valid && !fill_bus.ready;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state          <= st_hunt;
      vid_clk_last   <= 1'b0;
      hs_last        <= 1'b0;
      vs_last        <= 1'b0;
      line_cnt       <= COUNT_RESET;
      pixel_cnt      <= COUNT_RESET;
      field_top      <= 1'b0;
      capture_active <= 1'b0;
      push_valid     <= 1'b0;
      push_word      <= WORD_RESET;
      overflow       <= 1'b0;
    end else begin
      state          <= next_state;
      vid_clk_last   <= vid_clk_now;
      hs_last        <= next_hs_last;
      vs_last        <= next_vs_last;
      line_cnt       <= next_line_cnt;
      pixel_cnt      <= next_pixel_cnt;
      field_top      <= next_field_top;
      capture_active <= next_capture_active;
      push_valid     <= next_push_valid;
      push_word      <= next_push_word;
      overflow       <= next_overflow;
    end
  end

  assign fill_bus.valid = push_valid;
  assign fill_bus.data  = push_word;

  pixel_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys (clk_sys),
    .rst     (rst),
    .fill    (fill_bus.sink),
    .drain   (drain_bus.source)
  );

  // Buffer head and valid bit are flops inside the buffer.
  assign drain_bus.ready = pixel_ready;
  assign pixel_valid     = drain_bus.valid;
  assign pixel_top       = drain_bus.data[TOP_BIT];
  assign pixel_luma      = drain_bus.data[LUMA_LSB +: LANE_W];
  assign pixel_chroma    = drain_bus.data[CHROMA_LSB +: LANE_W];

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // The window checks compare against the configuration as it stands, so
  // the window may only be moved while the capture flag is low.
  sample_on_rise_a: assert property (pix_evt |-> $rose(vid_clk_now)) // R1
    else $error("Sample taken away from a video clock rising edge.");

  qualifier_match_a: assert property (pix_evt |-> qual_now == qualifier_polarity) // R2
    else $error("Sample taken with the qualifier at the wrong level.");

  pin_parity_a: assert property ((pix_evt && external_parity_enable) |=> // R5
      field_top == ($past(par_now) == $past(upper_parity_level)))
    else $error("Field identity does not follow the parity pin.");

  sync_parity_a: assert property ((pix_evt && !external_parity_enable && v_edge) |=> // R6
      field_top == ($past(hs_now) == $past(upper_parity_level)))
    else $error("Field identity does not follow line sync at the frame edge.");

  field_hold_a: assert property ((!pix_evt || (!external_parity_enable && !v_edge)) |=> // R4
      $stable(field_top))
    else $error("Field identity changed without a cause.");

  line_start_a: assert property (capture_active |-> line_cnt >= first_line_count) // R7
    else $error("Capture active above the first line.");

  line_end_a: assert property (capture_active |-> line_cnt <= last_line_count) // R8
    else $error("Capture active below the last line.");

  pixel_start_a: assert property (capture_active |-> pixel_cnt >= first_pixel_count) // R9
    else $error("Capture active before the first pixel.");

  pixel_end_a: assert property (capture_active |-> pixel_cnt <= last_pixel_count) // R10
    else $error("Capture active after the last pixel.");

  falling_line_edge_a: assert property ((pix_evt && line_sync_edge_select && hs_last && // R11
      !hs_now) |=> pixel_cnt == COUNT_RESET)
    else $error("Pixel count not cleared on the falling line sync edge.");

  frame_edge_clear_a: assert property ((pix_evt && v_edge) |=> // R12
      line_cnt == COUNT_RESET && state == st_locked)
    else $error("Line count not cleared on the active frame sync edge.");

  count_saturate_a: assert property ((pix_evt && !h_edge && pixel_cnt == COUNT_MAX) |=> // R13
      pixel_cnt == COUNT_MAX)
    else $error("Pixel count wrapped past its ten-bit limit.");

  window_push_a: assert property ((pix_evt && win) |=> push_valid ##1 // R15
      (pixel_valid || overflow))
    else $error("Windowed sample did not reach the buffer within two cycles.");

  pixel_step_a: assert property ((pix_evt && !h_edge && pixel_cnt < COUNT_MAX) |=> // R15
      pixel_cnt == $past(pixel_cnt) + 10'h001)
    else $error("Pixel count did not advance by one on a sample.");

  hunt_lockout_a: assert property ((pix_evt && state == st_hunt && !v_edge) |=> // R7
      !push_valid)
    else $error("Sample pushed before the first frame edge.");

  buffer_drop_a: assert property ((push_valid && !fill_bus.ready) |=> overflow) // R15
    else $error("Refused push was not flagged as a drop.");

  cover_window_c: cover property (pix_evt ##1 $rose(capture_active));
  cover_field_c:  cover property (pix_evt && v_edge && !external_parity_enable);
  cover_full_c:   cover property (push_valid && !fill_bus.ready);
  cover_drain_c:  cover property (pixel_valid && pixel_ready);
  cover_sat_c:    cover property (pix_evt && pixel_cnt == COUNT_MAX);

endmodule : video_input_sampler
`default_nettype wire

//--- video_source_model.sv
/*
  Behavioural video source for the sampler bench: double-rate clock,
  qualifier, syncs, lanes and parity pin, one lead-in line and one frame
  for each call of play.
  Assumes a single caller; the clock stands still between frames.
*/
`timescale 1ns/10ps
`default_nettype none
module video_source_model #(
  parameter int PIX   = 12,
  parameter int LINES = 6
) (
  // Pins towards the sampler.
  output var logic       video_clk,
  output var logic       qual,
  output var logic [7:0] luma,
  output var logic [7:0] chroma,
  output var logic       hs,
  output var logic       vs,
  output var logic       par_pin,
  // Behaviour chosen by the bench.
  input  wire logic      qpol,
  input  wire logic      hs_inv,
  input  wire logic      vs_inv,
  input  wire logic      vs_late,
  input  wire logic      par_level
);
  initial begin
    video_clk = 1'b0;
    qual   = 1'b0;
    luma   = 8'h00;
    chroma = 8'h00;
    hs     = 1'b0;
    vs     = 1'b0;
    par_pin = 1'b0;
  end

  // One qualified and one unqualified rising edge. The unqualified slot
  // carries inverted values, so a sampler taking the wrong edge sees garbage.
  task automatic emit(input int l, input int s, input logic v);
    qual    = qpol;
    luma    = 8'(s);
    chroma  = 8'(l);
    hs      = (s < 2) ^ hs_inv;
    vs      = v ^ vs_inv;
    par_pin = par_level;
    #160 video_clk = 1'b1;
    #160 video_clk = 1'b0;
    qual    = ~qpol;
    luma    = ~luma;
    chroma  = ~chroma;
    hs      = ~hs;
    vs      = ~vs;
    par_pin = ~par_pin;
    #160 video_clk = 1'b1;
    #160 video_clk = 1'b0;
  endtask : emit

  // The clock runs at a scaled-down rate, 320 ns a period, so that clk_sys sees every edge.
  task automatic play();
    #7;
    for (int s = 0; s < PIX; s++) begin
      emit(LINES, s, 1'b0);
    end
    for (int l = 0; l < LINES; l++) begin
      for (int s = 0; s < PIX; s++) begin
        emit(l, s, (l == 0) && (s >= (vs_late ? 4 : 0)));
      end
    end
  endtask : play
endmodule : video_source_model
`default_nettype wire
